/* File: src/fsia_pkg.sv */
/*
 * Shared constants for the fieldbus slave I/O and alarm block: register map,
 * field positions, reset values, timing counts and state encodings.
 * Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package fsia_pkg;
	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ       = 40;
	localparam int REFRESH_US    = 400;
	localparam int REFRESH_CYC   = REFRESH_US * CLK_MHZ;
	localparam int TICK_MS       = 1;
	localparam int MS_CYC        = TICK_MS * 1000 * CLK_MHZ;
	localparam int CONT_UNIT_MS  = 10;
	localparam int CNT_W         = 24;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFS_CMD  = 6'h00;
	localparam logic [5:0] OFS_SPD  = 6'h04;
	localparam logic [5:0] OFS_STAT = 6'h08;
	localparam logic [5:0] OFS_MSPD = 6'h0c;
	localparam logic [5:0] OFS_MTRQ = 6'h10;
	localparam logic [5:0] OFS_PADR = 6'h14;
	localparam logic [5:0] OFS_PDAT = 6'h18;
	localparam logic [5:0] OFS_PCTL = 6'h1c;
	localparam logic [5:0] OFS_CFG  = 6'h20;
	localparam logic [5:0] OFS_IST  = 6'h24;
	localparam logic [5:0] OFS_IMSK = 6'h28;

	// command word
	localparam int CMD_FWD  = 0;
	localparam int CMD_REV  = 1;
	localparam int CMD_ARST = 2;
	localparam int CMD_GP   = 3;
	localparam int GP_W     = 14;
	localparam int CMD_TOGGLE_BIT_ONE = 30;
	localparam int CMD_TOGGLE_BIT_TWO = 31;

	// configuration word
	localparam int CFG_FMT  = 0;
	localparam int CFG_MODE = 2;
	localparam int CFG_CONT = 4;
	localparam int CONT_W   = 11;
	localparam int CFG_TGL  = 16;
	localparam logic [31:0] CFG_RST = 32'h0000_0010;

	// parameter control, status and interrupt bits
	localparam int PCTL_RD   = 0;
	localparam int PCTL_WR   = 1;
	localparam int LINK_MAX  = 255;
	localparam int IRQ_W     = 4;
	localparam int IRQ_NET   = 0;
	localparam int IRQ_TGL   = 1;
	localparam int IRQ_PDONE = 2;
	localparam int IRQ_PERR  = 3;

	localparam logic [1:0] FMT_STD2 = 2'h3;
	localparam logic [1:0] MODE_STOP = 2'h0;
	localparam logic [1:0] MODE_NOALM = 2'h3;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_DEC = 2'h3;

	typedef enum logic [1:0] {
		FSIA_OK   = 2'b00,
		FSIA_HOLD = 2'b01,
		FSIA_TRIP = 2'b10
	} fsia_err_t;
endpackage

/* File: src/fsia_tgl_if.sv */
/*
 * Link between the main block and its toggle watchdog.
 * Assumes both ends share MCLK.
 */
`timescale 1ns/10ps
interface fsia_tgl_if;
	logic        tick;
	logic [1:0]  bits;
	logic [15:0] timeout;
	logic        clr;
	logic        err;
	logic        step;
	modport ctl (output tick, bits, timeout, clr, input err, step);
	modport mon (input tick, bits, timeout, clr, output err, step);
endinterface

/* File: src/fsia_tglmon.sv */
/*
 * Toggle watchdog: follows the two master toggle bits through a gray
 * sequence and flags a timeout in whole milliseconds.
 * Assumes tick is a one-cycle pulse every millisecond.
 */
`timescale 1ns/10ps
module fsia_tglmon
(
	// clock and reset
	input  wire logic MCLK,
	input  wire logic NRST,
	// watchdog link
	fsia_tgl_if.mon   tg
);
	import fsia_pkg::*;

	typedef struct packed {
		logic [1:0]  prev;
		logic [15:0] cnt;
		logic        err;
	} fsia_tgl_t;

	fsia_tgl_t q;
	fsia_tgl_t d;
	logic      step;

	// gray order 00-01-11-10: one bit moves per valid step
	function automatic logic [1:0] next_gray(input logic [1:0] v);
		next_gray = {v[0], ~v[1]};
	endfunction

	always_comb
	begin
		d = q;
		step = (tg.bits == next_gray(q.prev));
		if (step)
		begin
			d.prev = tg.bits;
			d.cnt = 16'h0000;
		end
		// a disabled watch clears the timer, so enabling it grants a full period
		else if (tg.timeout == 16'h0000)
			d.cnt = 16'h0000;
		else if (tg.tick && q.cnt != 16'hffff)
			d.cnt = q.cnt + 16'h0001;
		if (tg.clr)
			d.err = 1'b0;
		// zero timeout disables the watch; set wins over a same-cycle clear
		if (tg.timeout != 16'h0000 && q.cnt >= tg.timeout && !step)
			d.err = 1'b1;
	end

	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
			q <= '0;
		else
			q <= d;
	end

	assign tg.err = q.err;
	assign tg.step = step;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);

	err_cause_a: assert property ($rose(q.err) |-> $past(q.cnt) >= $past(tg.timeout)
		&& $past(tg.timeout) != 16'h0000)
		else $error("toggle error without full timeout");
	step_restart_a: assert property (step |=> q.cnt == 16'h0000)
		else $error("timer not restarted on toggle step");
	step_follow_a: assert property (step |=> q.prev == $past(tg.bits))
		else $error("toggle step not tracked");
	tgl_err_c: cover property ($rose(q.err));
endmodule // fsia_tglmon

/* File: src/fsia_top.sv */
/*
 * Fieldbus slave I/O block: cyclic command and status image, parameter
 * access, network alarm policy and toggle supervision, all behind AXI4-Lite.
 * Assumes the bus master writes the cyclic output image into the command
 * registers and that the inverter side answers parameter requests with ack.
 */
// How it works
// - image refreshed at most every 400 us
// - run bits applied as inverter commands
// - 16-bit speed word forwarded as command
// - status reported as individual bits
// - speed and torque monitors as words
// - parameters selected by link number 1-255
// - format two selects serial parameter numbering
// - bus failure raises network failure alarm
// - light alarm follows mode and continue time
// - heavy alarm trips at once, no delay
// - mode zero coasts to stop immediately
// - modes one, two hold run then stop
// - both toggle bits watched continuously
// - missing toggle pattern within timeout flags error
`timescale 1ns/10ps
module fsia_top
#(
	parameter int P_REFRESH_CYC = fsia_pkg::REFRESH_CYC,
	parameter int P_MS_CYC      = fsia_pkg::MS_CYC
)
(
	// clock and reset
	input  wire logic                       MCLK,
	input  wire logic                       NRST,
	// axi4-lite slave
	input  wire logic [fsia_pkg::ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic                       S_AXI_AWVALID,
	output wire logic                       S_AXI_AWREADY,
	input  wire logic [31:0]                S_AXI_WDATA,
	input  wire logic [3:0]                 S_AXI_WSTRB,
	input  wire logic                       S_AXI_WVALID,
	output wire logic                       S_AXI_WREADY,
	output wire logic [1:0]                 S_AXI_BRESP,
	output wire logic                       S_AXI_BVALID,
	input  wire logic                       S_AXI_BREADY,
	input  wire logic [fsia_pkg::ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic                       S_AXI_ARVALID,
	output wire logic                       S_AXI_ARREADY,
	output wire logic [31:0]                S_AXI_RDATA,
	output wire logic [1:0]                 S_AXI_RRESP,
	output wire logic                       S_AXI_RVALID,
	input  wire logic                       S_AXI_RREADY,
	output wire logic                       IRQ,
	// inverter commands
	output wire logic                       RUN_FWD,
	output wire logic                       RUN_REV,
	output wire logic                       ALM_RESET,
	output wire logic [fsia_pkg::GP_W-1:0]  GENERAL_PURPOSE_COMMAND_INPUTS,
	output wire logic [15:0]                SPEED_CMD,
	output wire logic                       COAST_STOP,
	output wire logic                       NETWORK_FAILURE_ALARM,
	output wire logic                       TOGGLE_ERR,
	// inverter state and bus health
	input  wire logic                       INV_RUNNING,
	input  wire logic                       INV_BRAKING,
	input  wire logic                       INV_TRQ_LIMIT,
	input  wire logic                       INV_ALM_RELAY,
	input  wire logic [15:0]                INV_SPEED,
	input  wire logic [15:0]                INV_TRQ_CUR,
	input  wire logic                       BUS_LIGHT_ERR,
	input  wire logic                       BUS_HEAVY_ERR,
	// parameter store
	output wire logic                       PAR_REQ,
	output wire logic                       PAR_WR,
	output wire logic                       PAR_BY_SERIAL,
	output wire logic [15:0]                PAR_ADDR,
	output wire logic [15:0]                PAR_WDATA,
	input  wire logic [15:0]                PAR_RDATA,
	input  wire logic                       PAR_ACK
);
	import fsia_pkg::*;

	localparam logic [CNT_W-1:0] REF_LAST = CNT_W'(P_REFRESH_CYC - 1);
	localparam logic [CNT_W-1:0] MS_LAST  = CNT_W'(P_MS_CYC - 1);

	typedef struct packed {
		logic                    aw_ok;
		logic [ADDR_W-1:0]       awa;
		logic                    w_ok;
		logic [31:0]             wd;
		logic [3:0]              ws;
		logic                    bv;
		logic [1:0]              br;
		logic                    rv;
		logic [31:0]             rd;
		logic [1:0]              rr;
		logic [31:0]             cmd;
		logic [15:0]             spd;
		logic [31:0]             cfg;
		logic [IRQ_W-1:0]        ist;
		logic [IRQ_W-1:0]        imsk;
		logic [15:0]             padr;
		logic [15:0]             pdat;
		logic                    pbusy;
		logic                    pwr;
		logic                    pser;
		logic                    perr;
		logic [CNT_W-1:0]        ref_cnt;
		logic [CNT_W-1:0]        ms_cnt;
		logic [2:0]              run;
		logic [GP_W-1:0]         gp;
		logic [15:0]             spd_o;
		logic [3:0]              stat;
		logic [15:0]             mspd;
		logic [15:0]             mtrq;
		fsia_err_t               est;
		logic [14:0]             hold_ms;
		logic                    tgl_err;
	} fsia_state_t;

	fsia_state_t q;
	fsia_state_t d;
	logic        refresh;
	logic        ms_tick;
	logic        wr_do;
	logic        rd_hit;
	logic [31:0] rd_word;
	logic [IRQ_W-1:0] ev;
	logic [14:0] cont_ms;
	logic [15:0] lnk;

	fsia_tgl_if tgi ();

	// byte-lane merge, shared by the writable data registers; IST and PCTL act on byte 0 only
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	// ------------------------------------------------------------
	// register read decode
	// ------------------------------------------------------------
	always_comb
	begin
		rd_hit = 1'b1;
		rd_word = 32'h0000_0000;
		case (S_AXI_ARADDR)
			OFS_CMD:  rd_word = q.cmd;
			OFS_SPD:  rd_word = {16'h0000, q.spd};
			OFS_STAT: rd_word = {24'h00_0000, (q.est != FSIA_OK), (q.est == FSIA_HOLD), q.tgl_err,
				(q.est == FSIA_TRIP), q.stat};
			OFS_MSPD: rd_word = {16'h0000, q.mspd};
			OFS_MTRQ: rd_word = {16'h0000, q.mtrq};
			OFS_PADR: rd_word = {16'h0000, q.padr};
			OFS_PDAT: rd_word = {16'h0000, q.pdat};
			OFS_PCTL: rd_word = {30'h0000_0000, q.perr, q.pbusy};
			OFS_CFG:  rd_word = q.cfg;
			OFS_IST:  rd_word = {28'h000_0000, q.ist};
			OFS_IMSK: rd_word = {28'h000_0000, q.imsk};
			default:  rd_hit = 1'b0;
		endcase
	end

	assign refresh = (q.ref_cnt == REF_LAST);
	assign ms_tick = (q.ms_cnt == MS_LAST);
	assign wr_do = q.aw_ok && q.w_ok && !q.bv;
	// zero continue time is taken as the 10 ms minimum
	assign cont_ms = 15'((q.cfg[CFG_CONT +: CONT_W] == 11'h000 ? 11'h001 : q.cfg[CFG_CONT +: CONT_W])
		* CONT_UNIT_MS);
	assign lnk = q.padr;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		d = q;
		ev = '0;
		d.ref_cnt = refresh ? '0 : q.ref_cnt + 1'b1;
		d.ms_cnt = ms_tick ? '0 : q.ms_cnt + 1'b1;

		// bus channels
		if (S_AXI_AWVALID && S_AXI_AWREADY)
		begin
			d.aw_ok = 1'b1;
			d.awa = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY)
		begin
			d.w_ok = 1'b1;
			d.wd = S_AXI_WDATA;
			d.ws = S_AXI_WSTRB;
		end
		if (q.bv && S_AXI_BREADY)
			d.bv = 1'b0;
		if (q.rv && S_AXI_RREADY)
			d.rv = 1'b0;
		if (S_AXI_ARVALID && S_AXI_ARREADY)
		begin
			d.rv = 1'b1;
			d.rd = rd_hit ? rd_word : 32'h0000_0000;
			d.rr = rd_hit ? RESP_OK : RESP_DEC;
		end
		if (wr_do)
		begin
			d.aw_ok = 1'b0;
			d.w_ok = 1'b0;
			d.bv = 1'b1;
			d.br = RESP_OK;
			case (q.awa)
				OFS_CMD:  d.cmd = merge(q.cmd, q.wd, q.ws);
				OFS_SPD:  d.spd = 16'(merge({16'h0000, q.spd}, q.wd, q.ws));
				OFS_PADR: d.padr = 16'(merge({16'h0000, q.padr}, q.wd, q.ws));
				OFS_PDAT: d.pdat = 16'(merge({16'h0000, q.pdat}, q.wd, q.ws));
				OFS_CFG:  d.cfg = merge(q.cfg, q.wd, q.ws);
				OFS_IST:  d.ist = q.ist & ~(q.ws[0] ? q.wd[IRQ_W-1:0] : '0);
				OFS_IMSK: d.imsk = IRQ_W'(merge({28'h000_0000, q.imsk}, q.wd, q.ws));
				OFS_PCTL:
				begin
					// start ignored while a transfer is still pending
					if (q.ws[0] && !q.pbusy && (q.wd[PCTL_RD] || q.wd[PCTL_WR]))
					begin
						d.pwr = q.wd[PCTL_WR];
						d.pser = (q.cfg[CFG_FMT +: 2] == FMT_STD2);
						if (d.pser || (lnk != 16'h0000 && lnk <= 16'(LINK_MAX)))
						begin
							d.pbusy = 1'b1;
							d.perr = 1'b0;
						end
						else
						begin
							d.perr = 1'b1;
							ev[IRQ_PERR] = 1'b1;
						end
					end
				end
				OFS_STAT, OFS_MSPD, OFS_MTRQ: ;
				default:  d.br = RESP_DEC;
			endcase
		end

		// parameter store handshake
		if (q.pbusy && PAR_ACK)
		begin
			d.pbusy = 1'b0;
			ev[IRQ_PDONE] = 1'b1;
			if (!q.pwr)
				d.pdat = PAR_RDATA;
		end

		// network failure policy
		case (q.est)
			FSIA_OK:
			begin
				d.hold_ms = 15'h0000;
				if (BUS_HEAVY_ERR)
					d.est = FSIA_TRIP;
				else if (BUS_LIGHT_ERR)
					d.est = (q.cfg[CFG_MODE +: 2] == MODE_STOP) ? FSIA_TRIP : FSIA_HOLD;
			end
			FSIA_HOLD:
			begin
				if (BUS_HEAVY_ERR)
					d.est = FSIA_TRIP;
				else if (!BUS_LIGHT_ERR)
					d.est = FSIA_OK;
				else if (q.cfg[CFG_MODE +: 2] == MODE_STOP)
					d.est = FSIA_TRIP;
				else if (q.cfg[CFG_MODE +: 2] != MODE_NOALM && ms_tick)
				begin
					d.hold_ms = q.hold_ms + 15'h0001;
					if (d.hold_ms >= cont_ms)
						d.est = FSIA_TRIP;
				end
			end
			FSIA_TRIP:
			begin
				// trip stays until the master resets with the bus healthy
				if (q.run[CMD_ARST] && !BUS_LIGHT_ERR && !BUS_HEAVY_ERR)
					d.est = FSIA_OK;
			end
			default: d.est = FSIA_TRIP;
		endcase
		if (d.est == FSIA_TRIP && q.est != FSIA_TRIP)
			ev[IRQ_NET] = 1'b1;

		// cyclic image exchange
		if (refresh)
		begin
			d.stat = {INV_ALM_RELAY, INV_TRQ_LIMIT, INV_BRAKING, INV_RUNNING};
			d.mspd = INV_SPEED;
			d.mtrq = INV_TRQ_CUR;
			d.run[CMD_ARST] = q.cmd[CMD_ARST];
			// hold state keeps the last good run command
			if (q.est == FSIA_OK && d.est == FSIA_OK)
			begin
				d.run[CMD_REV:CMD_FWD] = q.cmd[CMD_REV:CMD_FWD];
				d.gp = q.cmd[CMD_GP +: GP_W];
				d.spd_o = q.spd;
			end
		end
		if (d.est == FSIA_TRIP)
			d.run[CMD_REV:CMD_FWD] = 2'b00;

		d.tgl_err = tgi.err;
		if (tgi.err && !q.tgl_err)
			ev[IRQ_TGL] = 1'b1;

		// set wins over a same-cycle clear
		d.ist = d.ist | ev;
	end

	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			q <= '0;
			q.cfg <= CFG_RST;
			q.est <= FSIA_OK;
		end
		else
			q <= d;
	end

	// ------------------------------------------------------------
	// toggle watchdog
	// ------------------------------------------------------------
	assign tgi.tick = ms_tick;
	assign tgi.bits = {q.cmd[CMD_TOGGLE_BIT_TWO], q.cmd[CMD_TOGGLE_BIT_ONE]};
	assign tgi.timeout = q.cfg[CFG_TGL +: 16];
	assign tgi.clr = q.run[CMD_ARST];

	fsia_tglmon u_tgl
	(
		.MCLK (MCLK),
		.NRST (NRST),
		.tg   (tgi.mon)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign S_AXI_AWREADY = !q.aw_ok && !q.bv;
	assign S_AXI_WREADY = !q.w_ok && !q.bv;
	assign S_AXI_BVALID = q.bv;
	assign S_AXI_BRESP = q.br;
	assign S_AXI_ARREADY = !q.rv;
	assign S_AXI_RVALID = q.rv;
	assign S_AXI_RDATA = q.rd;
	assign S_AXI_RRESP = q.rr;
	assign IRQ = |(q.ist & q.imsk);
	assign RUN_FWD = q.run[CMD_FWD];
	assign RUN_REV = q.run[CMD_REV];
	assign ALM_RESET = q.run[CMD_ARST];
	assign GENERAL_PURPOSE_COMMAND_INPUTS = q.gp;
	assign SPEED_CMD = q.spd_o;
	assign COAST_STOP = (q.est == FSIA_TRIP);
	assign NETWORK_FAILURE_ALARM = (q.est == FSIA_TRIP);
	assign TOGGLE_ERR = q.tgl_err;
	assign PAR_REQ = q.pbusy;
	assign PAR_WR = q.pwr;
	assign PAR_BY_SERIAL = q.pser;
	assign PAR_ADDR = q.padr;
	assign PAR_WDATA = q.pdat;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!NRST);

	refresh_gate_a: assert property ($changed(SPEED_CMD) |-> $past(refresh))
		else $error("speed command changed between refreshes");
	run_apply_a: assert property ((refresh && q.est == FSIA_OK && d.est == FSIA_OK)
		|=> RUN_FWD == $past(q.cmd[CMD_FWD]))
		else $error("run command not applied at refresh");
	speed_fwd_a: assert property ((refresh && q.est == FSIA_OK && d.est == FSIA_OK)
		|=> SPEED_CMD == $past(q.spd))
		else $error("speed reference not forwarded");
	status_cap_a: assert property (refresh
		|=> q.stat == $past({INV_ALM_RELAY, INV_TRQ_LIMIT, INV_BRAKING, INV_RUNNING}))
		else $error("status bits not captured");
	mon_word_a: assert property (refresh |=> q.mspd == $past(INV_SPEED) && q.mtrq == $past(INV_TRQ_CUR))
		else $error("monitor words not captured");
	link_range_a: assert property ((PAR_REQ && !PAR_BY_SERIAL)
		|-> (PAR_ADDR != 16'h0000 && PAR_ADDR <= 16'h00ff))
		else $error("link number out of range");
	serial_sel_a: assert property ($rose(PAR_REQ) |-> PAR_BY_SERIAL == ($past(q.cfg[1:0]) == FMT_STD2))
		else $error("numbering does not follow format");
	heavy_trip_a: assert property (BUS_HEAVY_ERR |=> NETWORK_FAILURE_ALARM && COAST_STOP)
		else $error("heavy alarm did not trip at once");
	mode0_trip_a: assert property ((q.est == FSIA_OK && BUS_LIGHT_ERR && q.cfg[3:2] == MODE_STOP)
		|=> NETWORK_FAILURE_ALARM ##1 !RUN_FWD && !RUN_REV)
		else $error("mode zero did not coast to stop");
	hold_keep_a: assert property ((q.est == FSIA_HOLD && d.est == FSIA_HOLD)
		|=> $stable(RUN_FWD) && $stable(SPEED_CMD))
		else $error("run command moved while holding");
	no_early_a: assert property (($past(q.est) == FSIA_HOLD && $rose(NETWORK_FAILURE_ALARM)
		&& !$past(BUS_HEAVY_ERR) && $past(q.cfg[3:2]) != MODE_STOP)
		|-> $past(q.hold_ms) + 15'h0001 >= $past(cont_ms))
		else $error("light alarm tripped before continue time");

	heavy_c: cover property (BUS_HEAVY_ERR ##1 NETWORK_FAILURE_ALARM);
	hold_recover_c: cover property (q.est == FSIA_HOLD ##1 q.est == FSIA_OK);
	param_done_c: cover property (PAR_REQ && PAR_ACK);
	tgl_step_c: cover property (tgi.step);
endmodule // fsia_top

/* File: tb/fsia_inv_model.sv */
/*
 * Behavioural parameter store of the inverter, answering the block's
 * parameter requests with a one-cycle acknowledge after a chosen delay.
 * Assumes the request stays up until the cycle after the acknowledge.
 */
`timescale 1ns/10ps
module fsia_inv_model
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// parameter port
	input  wire logic        req,
	input  wire logic        wr,
	input  wire logic [15:0] addr,
	input  wire logic [15:0] wdata,
	input  wire logic [3:0]  dly,
	output logic      [15:0] rdata,
	output logic             ack
);
	logic [15:0] mem [256];
	logic [15:0] last_q;
	logic [3:0]  cnt_q;
	logic        done_q;

	// released data shows the inverse, so a stale word cannot pass
	assign rdata = ack ? last_q : ~last_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ack <= 1'b0;
			cnt_q <= 4'h0;
			done_q <= 1'b0;
			last_q <= 16'h0;
		end
		else
		begin
			ack <= 1'b0;
			if (!req)
				done_q <= 1'b0;
			else if (!done_q && cnt_q == dly)
			begin
				ack <= 1'b1;
				done_q <= 1'b1;
				cnt_q <= 4'h0;
				last_q <= mem[addr[7:0]];
				if (wr)
					mem[addr[7:0]] <= wdata;
			end
			else if (!done_q)
				cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule // fsia_inv_model

/* File: tb/tb_fsia_top.sv */
/*
 * Self-checking bench of the fieldbus slave block: register bus, cyclic
 * image, parameter access, alarm policy and toggle watch.
 * Assumes short refresh and millisecond counts set by parameters.
 */
`timescale 1ns/10ps
module tb_fsia_top;
	import fsia_pkg::*;
	localparam int RC = 20;
	logic MCLK, NRST, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, irq, fwd, coast, nfa, terr;
	logic lerr, herr, preq, pwr, pser, pack, rev, arst;
	logic [5:0] awa, ara;
	logic [31:0] wd, rd_, r;
	logic [1:0] rresp, bresp;
	logic [3:0] inv, dly;
	logic [13:0] gp;
	logic [15:0] ms, mt, pa, pwd, prd, scmd;
	logic [29:0] img;
	logic [1:0] tg [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
	logic [65:0] q[$];
	int err_count, checks, seed, cyc, last_c;

	fsia_top #(.P_REFRESH_CYC(RC), .P_MS_CYC(10)) DUT (
		.MCLK(MCLK), .NRST(NRST), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rd_), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .IRQ(irq),
		.RUN_FWD(fwd), .RUN_REV(rev), .ALM_RESET(arst), .GENERAL_PURPOSE_COMMAND_INPUTS(gp), .SPEED_CMD(scmd),
		.COAST_STOP(coast), .NETWORK_FAILURE_ALARM(nfa), .TOGGLE_ERR(terr), .INV_RUNNING(inv[0]),
		.INV_BRAKING(inv[1]), .INV_TRQ_LIMIT(inv[2]), .INV_ALM_RELAY(inv[3]), .INV_SPEED(ms), .INV_TRQ_CUR(mt),
		.BUS_LIGHT_ERR(lerr), .BUS_HEAVY_ERR(herr), .PAR_REQ(preq), .PAR_WR(pwr), .PAR_BY_SERIAL(pser),
		.PAR_ADDR(pa), .PAR_WDATA(pwd), .PAR_RDATA(prd), .PAR_ACK(pack));

	fsia_inv_model INV (.clk(MCLK), .rst_n(NRST), .req(preq), .wr(pwr), .addr(pa), .wdata(pwd),
		.dly(dly), .rdata(prd), .ack(pack));

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge MCLK);
	endtask

	task automatic axw(input logic [5:0] a, input logic [31:0] d);
		logic ta, tw, da, dw;
		da = 0;
		dw = 0;
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		br <= 1;
		while (!(da && dw))
		begin
			@(negedge MCLK);
			ta = awv && awr;
			tw = wv && wr_;
			@(posedge MCLK);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
			da |= ta;
			dw |= tw;
		end
		do @(negedge MCLK); while (bv !== 1'b1);
		// unmapped or unaligned offsets answer with a decode error
		chk("bresp", bresp, (a > OFS_IMSK || a[1:0] != 2'h0) ? RESP_DEC : RESP_OK);
		@(posedge MCLK);
		br <= 0;
		@(posedge MCLK);
	endtask

	// the expected word goes on the queue; the watcher below compares it
	task automatic axr(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] rs);
		q.push_back({rs, m, e & m});
		ara <= a;
		arv <= 1;
		rr <= 1;
		do @(negedge MCLK); while (arr !== 1'b1);
		@(posedge MCLK);
		arv <= 0;
		do @(negedge MCLK); while (rv !== 1'b1);
		@(posedge MCLK);
		rr <= 0;
		@(posedge MCLK);
	endtask

	// leave a trip: error gone, alarm reset applied for one refresh
	task automatic clr;
		lerr <= 0;
		axw(OFS_CMD, 32'h5);
		wt(RC + 2);
		chk("alarm reset", arst, 1);
		axw(OFS_CMD, 32'h1);
		wt(RC + 2);
	endtask

	task end_of_test;
		$display("errors %0d checks %0d", err_count, checks);
		if (err_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// watchers
	// ------------------------------------------------------------
	always @(posedge MCLK)
		if (rv === 1'b1 && rr === 1'b1 && q.size() > 0)
		begin
			chk("rdata", rd_ & q[0][63:32], q[0][31:0]);
			chk("rresp", rresp, q[0][65:64]);
			void'(q.pop_front());
		end

	always @(negedge MCLK)
	begin
		cyc++;
		if ({gp, scmd} !== img)
		begin
			chk("refresh gap", 32'(cyc - last_c >= RC), 1);
			last_c = cyc;
			img = {gp, scmd};
		end
	end

	initial
	begin
		MCLK = 0;
		forever #12.5 MCLK = ~MCLK;
	end

	initial
	begin
		wt(20000);
		err_count++;
		end_of_test;
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		seed = 32'h5f1ce9ad;
		{err_count, checks, cyc, last_c} = 0;
		{NRST, awv, wv, br, arv, rr, lerr, herr} = 0;
		{awa, ara, wd, inv, ms, mt, img} = 0;
		dly = 4'h0;
		wt(4);
		NRST <= 1;
		wt(1);
		axr(OFS_CFG, CFG_RST, 32'hffffffff, RESP_OK);
		axr(6'h3c, 32'h0, 32'hffffffff, RESP_DEC);
		axw(6'h3c, 32'h0);
		r = $random(seed);
		inv <= r[3:0];
		ms <= r[15:0];
		mt <= r[31:16];
		axw(OFS_SPD, {16'h0, r[31:16]});
		axw(OFS_CMD, {15'h0, r[16:3], 3'b001});
		wt(RC + 2);
		chk("run fwd", fwd, 1);
		chk("gp cmd", gp, r[16:3]);
		chk("speed", scmd, r[31:16]);
		chk("run rev", rev, 0);
		axr(OFS_STAT, {28'h0, r[3:0]}, 32'hf, RESP_OK);
		axr(OFS_MSPD, r[15:0], 32'hffff, RESP_OK);
		axr(OFS_MTRQ, r[31:16], 32'hffff, RESP_OK);
		r = $random(seed);
		axw(OFS_PADR, 32'd255);
		axw(OFS_PDAT, {16'h0, r[15:0]});
		axw(OFS_PCTL, 32'h2);
		wt(12);
		dly <= 4'h4;
		axw(OFS_PCTL, 32'h1);
		chk("by serial", pser, 0);
		wt(14);
		axr(OFS_PDAT, r[15:0], 32'hffff, RESP_OK);
		axr(OFS_IST, 32'h4, 32'h4, RESP_OK);
		axw(OFS_PADR, 32'h0);
		axw(OFS_PCTL, 32'h1);
		wt(4);
		axr(OFS_IST, 32'h8, 32'h8, RESP_OK);
		axw(OFS_CFG, CFG_RST | {30'h0, FMT_STD2});
		axw(OFS_PADR, 32'h300);
		axw(OFS_PCTL, 32'h1);
		chk("by serial", pser, 1);
		wt(14);
		axw(OFS_IST, 32'hf);
		axw(OFS_CFG, CFG_RST | {28'h0, MODE_NOALM, 2'h0});
		lerr <= 1;
		wt(20);
		chk("no alarm", nfa, 0);
		herr <= 1;
		wt(2);
		chk("heavy", nfa, 1);
		herr <= 0;
		chk("masked irq", irq, 0);
		axw(OFS_IMSK, 32'h1);
		chk("irq", irq, 1);
		axr(OFS_IST, 32'h1, 32'h1, RESP_OK);
		clr;
		chk("cleared", nfa, 0);
		axw(OFS_IST, 32'h1);
		chk("irq clear", irq, 0);
		axw(OFS_CFG, CFG_RST);
		lerr <= 1;
		wt(2);
		chk("coast", coast, 1);
		chk("alarm", nfa, 1);
		clr;
		for (int m = 1; m < 3; m++)
		begin
			axw(OFS_CFG, 32'h10 | (m << 2));
			lerr <= 1;
			wt(60);
			chk("hold", nfa, 0);
			chk("held run", fwd, 1);
			wt(60);
			chk("late trip", nfa, 1);
			clr;
		end
		axw(OFS_CFG, 32'h0008_0010);
		for (int i = 0; i < 6; i++)
		begin
			axw(OFS_CMD, {tg[i % 4], 27'h0, 3'b001});
			wt(RC + 6);
			chk("toggle ok", terr, 0);
		end
		wt(120);
		chk("toggle err", terr, 1);
		wt(4);
		end_of_test;
	end
endmodule // tb_fsia_top
